// file: verilog/uart_flags_consts.svh
// Purpose: Offsets, bit positions, reset values and sizes of the receive status block.
// Assumes: Included by the package and by every design file; guarded.
// Notes:   All offsets are byte addresses on a 32-bit APB bus.
`ifndef UART_FLAGS_CONSTS_SVH
`define UART_FLAGS_CONSTS_SVH

// Register byte offsets.
`define OFS_RX_DATA    12'h000
`define OFS_LINE_COND  12'h004
`define OFS_PEER_SIG   12'h008
`define OFS_CONFIG     12'h00c
`define OFS_IRQ_STAT   12'h010
`define OFS_IRQ_MASK   12'h014

// Line condition flag positions.
`define LC_CHAR_WAIT   0
`define LC_OVERRUN     1
`define LC_PARITY      2
`define LC_FIFO_FAULT  7

// Peer signal flag positions: change bits low, states high.
`define PS_CTS_CHG     0
`define PS_DSR_CHG     1
`define PS_RI_RISE     2
`define PS_DCD_CHG     3
`define PS_CTS_STATE   4

// Configuration bit positions and reset value.
`define CFG_FIFO_EN    0
`define CFG_PAR_EN     1
`define CFG_PAR_EVEN   2
`define CFG_LOOP       3
`define CFG_LOOP_LO    4
`define CFG_RESET      8'h00

// Interrupt event positions and reset values.
`define EV_RX_DATA     0
`define EV_LINE_ERR    1
`define EV_PEER_CHG    2
`define IRQ_W          3
`define IRQ_MASK_RESET 3'h0

// Receive FIFO geometry and entry layout.
`define FIFO_DEPTH     16
`define FIFO_AW        4
`define ENTRY_W        11
`define ENT_PAR        8
`define ENT_FRM        9
`define ENT_BRK        10

`endif

// file: verilog/uart_flags_pkg.sv
// Purpose: State types of the receive status block.
// Assumes: Constants come from the guarded header.
// Notes:   Each design module keeps all of its state in one of these structs.
`include "uart_flags_consts.svh"

package uart_flags_pkg;

  typedef logic [`ENTRY_W-1:0] entry_t;

  typedef struct packed {
    entry_t [`FIFO_DEPTH-1:0] mem;
    logic   [`FIFO_AW-1:0]    wrPtr;
    logic   [`FIFO_AW-1:0]    rdPtr;
    logic   [`FIFO_AW:0]      count;
  } fifo_state_t;

  typedef struct packed {
    logic [3:0] stage1;
    logic [3:0] stage2;
  } sync_state_t;

  typedef struct packed {
    logic [7:0]         rxShift;
    logic               overrun;
    logic               parHide;
    logic               fifoFault;
    logic [7:0]         cfgReg;
    logic               fifoEnPrev;
    logic [3:0]         peerPrev;
    logic [3:0]         peerChg;
    logic [`IRQ_W-1:0]  irqStat;
    logic [`IRQ_W-1:0]  irqMask;
    logic               irq;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
  } main_state_t;

endpackage

// file: verilog/rx_char_fifo.sv
// Purpose: Sixteen-entry receive FIFO holding each character with its error bits.
// Assumes: Push is never requested while full; pop never while empty.
// Notes:   Clear wins over push and pop in the same cycle.
`timescale 1ns/1ps
`include "uart_flags_consts.svh"

module rx_char_fifo
  import uart_flags_pkg::*;
(
  input  wire logic               ref_clk,    // System clock
  input  wire logic               rst,        // Synchronous reset, active high
  input  wire logic               clear,      // Discard all entries
  input  wire logic               push,       // Write one entry
  input  wire entry_t             pushEntry,  // Entry to write
  input  wire logic               pop,        // Drop the head entry
  output      entry_t             headEntry,  // Entry at the head
  output      logic               empty,      // No entry held
  output      logic               full,       // All entries held
  output      logic [`FIFO_AW:0]  count       // Entries held
);

  fifo_state_t cur_ff;
  fifo_state_t nxt_cur;

  always_comb begin
    nxt_cur = cur_ff;
    if (clear) begin
      nxt_cur.wrPtr = '0;
      nxt_cur.rdPtr = '0;
      nxt_cur.count = '0;
    end else begin
      if (push) begin
        nxt_cur.mem[cur_ff.wrPtr] = pushEntry;
        nxt_cur.wrPtr = cur_ff.wrPtr + 1'b1;
      end
      if (pop) begin
        nxt_cur.rdPtr = cur_ff.rdPtr + 1'b1;
      end
      if (push && !pop) begin
        nxt_cur.count = cur_ff.count + 1'b1;
      end else if (pop && !push) begin
        nxt_cur.count = cur_ff.count - 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign headEntry = cur_ff.mem[cur_ff.rdPtr];
  assign empty     = (cur_ff.count == '0);
  assign full      = (cur_ff.count == (`FIFO_AW+1)'(`FIFO_DEPTH));
  assign count     = cur_ff.count;

endmodule

// file: verilog/modem_pin_sync.sv
// Purpose: Brings the four active-low modem control pins into the clock domain.
// Assumes: Pins are asynchronous to ref_clk.
// Notes:   Reset value is all ones, the idle level of active-low pins.
`timescale 1ns/1ps
`include "uart_flags_consts.svh"

module modem_pin_sync
  import uart_flags_pkg::*;
(
  input  wire logic       ref_clk,  // System clock
  input  wire logic       rst,      // Synchronous reset, active high
  input  wire logic [3:0] pinsN,    // Raw pins {dcd, ri, dsr, cts}, active low
  output      logic [3:0] syncN     // Synchronised pins, same order
);

  sync_state_t cur_ff;
  sync_state_t nxt_cur;

  always_comb begin
    nxt_cur        = cur_ff;
    nxt_cur.stage1 = pinsN;
    nxt_cur.stage2 = cur_ff.stage1;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cur_ff <= '1;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign syncN = cur_ff.stage2;

endmodule

// file: verilog/uart_rx_status.sv
// Purpose: Receive line flags and modem status flags of a UART, with an APB slave.
// Assumes: The receive path delivers one completed character per rxCharValid pulse.
// Notes:   Reads take their side effects at the setup edge, writes at the access edge.
//
// Notes on behaviour
// - Parity flag bit 2 set when received parity mismatches the configured parity.
// - In FIFO mode the parity flag follows the character at the FIFO head.
// - Overrun flag bit 1 set when a character completes while the FIFO (without FIFO mode, the holding register) is full.
// - On overrun the new character overwrites the shift register contents.
// - On overrun nothing is pushed; queued characters stay untouched.
// - Data-ready bit 0 high while any unread character is held.
// - Data-ready bit 0 low when nothing is held; low after reset.
// - Present state of each modem input is readable in the peer register.
// - Change bits 0, 1 and 3 set on any change of their modem input; ring bit 2 on one edge only.
// - Reading the peer register clears all four change bits.
// - FIFO fault bit 7 set on parity, framing or break; cleared by line read.
// - Outside loopback, clear-to-send bit 4 is the complement of the pin.
// - Ring change bit 2 set only when the ring pin goes from 0 to 1.
`timescale 1ns/1ps
`include "uart_flags_consts.svh"

module uart_rx_status
  import uart_flags_pkg::*;
(
  input  wire logic        ref_clk,      // System clock, 20 MHz
  input  wire logic        rst,          // Synchronous reset, active high
  input  wire logic        psel,         // APB select
  input  wire logic        penable,      // APB access phase
  input  wire logic        pwrite,       // APB write
  input  wire logic [11:0] paddr,        // APB byte address
  input  wire logic [31:0] pwdata,       // APB write data
  output      logic [31:0] prdata,       // APB read data
  output      logic        pready,       // APB ready
  output      logic        pslverr,      // APB error on unmapped address
  input  wire logic        rxCharValid,  // Character completed, one-cycle pulse
  input  wire logic [7:0]  rxCharData,   // Completed character
  input  wire logic        rxParityBit,  // Parity bit as received
  input  wire logic        rxFrameBad,   // Stop bit missing
  input  wire logic        rxBreak,      // Break condition seen
  input  wire logic [3:0]  modemPinsN,   // Modem pins {dcd, ri, dsr, cts}, active low
  output      logic        irq           // Interrupt, level, active high
);

  // ****************************************************************
  // Sub-blocks
  // ****************************************************************

  main_state_t         cur_ff;
  main_state_t         nxt_cur;

  logic                fifoClear;
  logic                fifoPush;
  logic                fifoPop;
  entry_t              pushEntry;
  entry_t              headEntry;
  logic                fifoEmpty;
  logic                fifoFull;
  logic [`FIFO_AW:0]   fifoCount;
  logic [3:0]          modemSyncN;

  rx_char_fifo u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .clear     (fifoClear),
    .push      (fifoPush),
    .pushEntry (pushEntry),
    .pop       (fifoPop),
    .headEntry (headEntry),
    .empty     (fifoEmpty),
    .full      (fifoFull),
    .count     (fifoCount)
  );

  modem_pin_sync u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pinsN   (modemPinsN),
    .syncN   (modemSyncN)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************

  function automatic logic [31:0] word8(input logic [7:0] b);
    word8 = {24'h000000, b};
  endfunction

  function automatic logic [31:0] wordIrq(input logic [`IRQ_W-1:0] b);
    wordIrq = {{(32-`IRQ_W){1'b0}}, b};
  endfunction

  // Even parity wants an even count of ones over data and parity bit, odd wants odd.
  function automatic logic parityWrong(input logic [7:0] d, input logic p, input logic even);
    parityWrong = ((^d ^ p) == even);
  endfunction

  // ****************************************************************
  // Combinational view of the flags
  // ****************************************************************

  logic              setupRd;
  logic              accessWr;
  logic              fifoMode;
  logic              holdFull;
  logic              parityBad;
  logic              parityFlag;
  logic              entryFault;
  logic [3:0]        peerNow;
  logic [3:0]        peerEdge;
  logic [7:0]        lineWord;
  logic [7:0]        peerWord;
  logic              addrOk;
  logic              rdLine;
  logic              rdPeer;
  logic              rdData;
  logic [`IRQ_W-1:0] irqEvents;

  always_comb begin
    // Reads are decoded once, at the setup edge, so the access cycle never pops twice.
    setupRd  = psel && !penable && !pwrite;
    accessWr = psel && penable && pwrite && cur_ff.pready;
    fifoMode = cur_ff.cfgReg[`CFG_FIFO_EN];

    // Without FIFO mode the queue acts as a single holding register.
    holdFull = fifoMode ? fifoFull : !fifoEmpty;

    parityBad = cur_ff.cfgReg[`CFG_PAR_EN] &&
                parityWrong(rxCharData, rxParityBit, cur_ff.cfgReg[`CFG_PAR_EVEN]);

    pushEntry = {rxBreak, rxFrameBad, parityBad, rxCharData};

    fifoPush  = rxCharValid && !holdFull;

    entryFault = rxCharValid && (parityBad || rxFrameBad || rxBreak);

    parityFlag = !fifoEmpty && headEntry[`ENT_PAR] && !cur_ff.parHide;

    // Switching loopback can set change bits, since both views feed one detector.
    // present modem state
    if (cur_ff.cfgReg[`CFG_LOOP]) begin
      peerNow = cur_ff.cfgReg[`CFG_LOOP_LO +: 4];
    end else begin
      peerNow = ~modemSyncN;
    end

    peerEdge = peerNow ^ cur_ff.peerPrev;
    peerEdge[`PS_RI_RISE] = cur_ff.peerPrev[`PS_RI_RISE] && !peerNow[`PS_RI_RISE];

    lineWord = '0;
    lineWord[`LC_CHAR_WAIT]  = !fifoEmpty;
    lineWord[`LC_OVERRUN]    = cur_ff.overrun;
    lineWord[`LC_PARITY]     = parityFlag;
    lineWord[`LC_FIFO_FAULT] = cur_ff.fifoFault;

    peerWord = {peerNow, cur_ff.peerChg};

    // ************************************************************
    // Register decode
    // ************************************************************
    unique case (paddr)
      `OFS_RX_DATA, `OFS_LINE_COND, `OFS_PEER_SIG,
      `OFS_CONFIG, `OFS_IRQ_STAT, `OFS_IRQ_MASK: addrOk = 1'b1;
      default:                                   addrOk = 1'b0;
    endcase

    rdLine = setupRd && (paddr == `OFS_LINE_COND);
    rdPeer = setupRd && (paddr == `OFS_PEER_SIG);
    rdData = setupRd && (paddr == `OFS_RX_DATA);

    fifoPop   = rdData && !fifoEmpty;
    // Toggling FIFO mode flushes the queue, so no entry outlives a change of capacity.
    fifoClear = (fifoMode != cur_ff.fifoEnPrev);

    // ************************************************************
    // Interrupt events
    // ************************************************************
    irqEvents = '0;
    irqEvents[`EV_RX_DATA]  = fifoPush;
    irqEvents[`EV_LINE_ERR] = (rxCharValid && holdFull) || (fifoPush && parityBad);
    irqEvents[`EV_PEER_CHG] = |peerEdge;
  end

  // ****************************************************************
  // Next state
  // ****************************************************************

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.fifoEnPrev = fifoMode;
    nxt_cur.peerPrev   = peerNow;

    // ************************************************************
    // Receive flags
    // ************************************************************
    // The shift register only models the overwrite; software never reads it.
    // newest character wins
    if (rxCharValid) begin
      nxt_cur.rxShift = rxCharData;
    end

    // Hiding rather than clearing keeps the parity bit stored with its character.
    // read clears flags
    if (rdLine) begin
      nxt_cur.overrun   = 1'b0;
      nxt_cur.fifoFault = 1'b0;
      nxt_cur.parHide   = !fifoEmpty;
    end
    if (fifoPop || fifoClear) begin
      nxt_cur.parHide = 1'b0;
    end

    if (rxCharValid && holdFull) begin
      nxt_cur.overrun = 1'b1;
    end

    if (fifoPush && entryFault) begin
      nxt_cur.fifoFault = 1'b1;
    end

    // ************************************************************
    // Modem flags
    // ************************************************************
    // read clears changes
    if (rdPeer) begin
      nxt_cur.peerChg = '0;
    end
    nxt_cur.peerChg = nxt_cur.peerChg | peerEdge;

    // ************************************************************
    // Register writes
    // ************************************************************
    // Register writes land at the access edge only.
    // Unmapped or read-only offsets fall to the default and change nothing.
    if (accessWr) begin
      unique case (paddr)
        `OFS_CONFIG:   nxt_cur.cfgReg  = pwdata[7:0];
        `OFS_IRQ_MASK: nxt_cur.irqMask = pwdata[`IRQ_W-1:0];
        `OFS_IRQ_STAT: nxt_cur.irqStat = cur_ff.irqStat & ~pwdata[`IRQ_W-1:0];
        default:       nxt_cur.cfgReg  = cur_ff.cfgReg;
      endcase
    end
    // A new event in the clearing cycle survives.
    nxt_cur.irqStat = nxt_cur.irqStat | irqEvents;
    nxt_cur.irq     = |(nxt_cur.irqStat & nxt_cur.irqMask);

    // ************************************************************
    // Read data
    // ************************************************************
    // Setup phase latches read data and raises ready for the access phase.
    nxt_cur.pready  = psel && !penable;
    nxt_cur.pslverr = psel && !penable && !addrOk;
    if (setupRd) begin
      unique case (paddr)
        `OFS_RX_DATA:   nxt_cur.prdata = word8(fifoEmpty ? 8'h00 : headEntry[7:0]);
        `OFS_LINE_COND: nxt_cur.prdata = word8(lineWord);
        `OFS_PEER_SIG:  nxt_cur.prdata = word8(peerWord);
        `OFS_CONFIG:    nxt_cur.prdata = word8(cur_ff.cfgReg);
        `OFS_IRQ_STAT:  nxt_cur.prdata = wordIrq(cur_ff.irqStat);
        `OFS_IRQ_MASK:  nxt_cur.prdata = wordIrq(cur_ff.irqMask);
        default:        nxt_cur.prdata = 32'h00000000;
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cur_ff         <= '0;
      cur_ff.cfgReg  <= `CFG_RESET;
      cur_ff.irqMask <= `IRQ_MASK_RESET;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  assign prdata  = cur_ff.prdata;
  assign pready  = cur_ff.pready;
  assign pslverr = cur_ff.pslverr;
  assign irq     = cur_ff.irq;

endmodule

// file: tb/uart_rx_status_props.sv
// Purpose: Port-level assertions for uart_rx_status.
// Assumes: Attached by bind; sees the top ports only.
// Notes:   Loopback state is tracked from config writes.
`timescale 1ns/1ps
`include "uart_flags_consts.svh"

module uart_rx_status_props (
  input wire logic        ref_clk,      // Clock
  input wire logic        rst,          // Reset
  input wire logic        psel,         // Select
  input wire logic        penable,      // Access
  input wire logic        pwrite,       // Write
  input wire logic [11:0] paddr,        // Address
  input wire logic [31:0] pwdata,       // Write data
  input wire logic [31:0] prdata,       // Read data
  input wire logic        pready,       // Ready
  input wire logic        pslverr,      // Error
  input wire logic        rxCharValid,  // Char done
  input wire logic [7:0]  rxCharData,   // Char
  input wire logic        rxParityBit,  // Parity
  input wire logic        rxFrameBad,   // Frame
  input wire logic        rxBreak,      // Break
  input wire logic [3:0]  modemPinsN,   // Pins
  input wire logic        irq           // Interrupt
);
  logic [3:0] quiet_ff;
  logic [3:0] pinsOld_ff;
  logic       loopOn_ff;
  wire        rdPeer = psel && !penable && !pwrite && paddr == `OFS_PEER_SIG;
  wire        rdLine = psel && !penable && !pwrite && paddr == `OFS_LINE_COND;
  wire        wrDone = psel && penable && pready && pwrite;

  // Pins pass a two-stage sync, so state checks wait for a quiet spell.
  always_ff @(posedge ref_clk) begin
    pinsOld_ff <= modemPinsN;
    if (rst || pinsOld_ff != modemPinsN) begin
      quiet_ff <= 4'h0;
    end else if (quiet_ff != 4'hf) begin
      quiet_ff <= quiet_ff + 4'h1;
    end
    if (rst) begin
      loopOn_ff <= 1'b0;
    end else if (wrDone && paddr == `OFS_CONFIG) begin
      loopOn_ff <= pwdata[`CFG_LOOP];
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  a_setup_answer: assert property ((psel && !penable) |=> pready)
    else $error("no answer after setup");
  a_unmapped_err: assert property ((pready && paddr > `OFS_IRQ_MASK) |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_upper_zero: assert property ((pready && !pwrite) |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_data_ready: assert property (rxCharValid ##1 !psel ##1 rdLine |=> prdata[0])
    else $error("char waiting bit low after a char");
  a_peer_clear: assert property (rdPeer ##3 (rdPeer && quiet_ff >= 4'h8) |=> prdata[3:0] == 4'h0)
    else $error("change bits survive a read");
  a_peer_state: assert property ((rdPeer && quiet_ff >= 4'h4 && !loopOn_ff)
    |=> prdata[7:4] == ~$past(modemPinsN))
    else $error("peer state bits not pin complement");
  a_irq_masked: assert property ((wrDone && paddr == `OFS_IRQ_MASK && pwdata[2:0] == 3'h0)
    |-> ##2 !irq)
    else $error("irq high with all masked");

  c_char: cover property (rxCharValid);
  c_err: cover property (pslverr);
  c_irq: cover property (irq);
endmodule

bind uart_rx_status uart_rx_status_props u_uart_rx_status_props (.ref_clk, .rst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rxCharValid,
  .rxCharData, .rxParityBit, .rxFrameBad, .rxBreak, .modemPinsN, .irq);

// file: tb/modem_peer.sv
// Purpose: Modem model driving the four control pins.
// Assumes: Pins idle high, as active-low lines at rest.
// Notes:   Changes land just after a clock edge.
`timescale 1ns/1ps

module modem_peer (
  input  wire logic       ref_clk,  // Clock timing pin changes
  output      logic [3:0] pinsN     // Pins {dcd, ri, dsr, cts}, active low
);
  initial pinsN = 4'hf;

  task automatic setPins(input logic [3:0] v);
    @(posedge ref_clk);
    pinsN <= v;
  endtask
endmodule

// file: tb/tb_uart_rx_status.sv
// Purpose: Self-checking bench for uart_rx_status.
// Assumes: One APB transfer at a time.
// Notes:   Reset reads first, then table rows, then hand-written cases.
`timescale 1ns/1ps
`include "uart_flags_consts.svh"

module tb_uart_rx_status;
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] data;
    logic       pb;
    logic       frm;
    logic       brk;
  } row_t;
  logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, irq;
  logic        rxCharValid, rxParityBit, rxFrameBad, rxBreak, perr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdData;
  logic [7:0]  rxCharData;
  logic [3:0]  modemPinsN;
  logic        rdErr;
  int          n_mismatch, n_tests, cycles;
  row_t rows [6] = '{'{8'h03, 8'h55, 1'b0, 1'b0, 1'b0}, '{8'h03, 8'h55, 1'b1, 1'b0, 1'b0},
    '{8'h07, 8'h55, 1'b0, 1'b0, 1'b0}, '{8'h07, 8'h54, 1'b0, 1'b0, 1'b0},
    '{8'h01, 8'h54, 1'b0, 1'b1, 1'b0}, '{8'h01, 8'h00, 1'b0, 1'b0, 1'b1}};

  uart_rx_status u_uart_rx_status (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rxCharValid, .rxCharData, .rxParityBit,
    .rxFrameBad, .rxBreak, .modemPinsN, .irq);
  modem_peer u_modem_peer (.ref_clk, .pinsN(modemPinsN));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ****
  // Tasks
  // ****
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rdData = prdata;
    rdErr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input string nm, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    check(nm, rdData, {24'h0, e});
  endtask

  task automatic sendChar(input logic [7:0] d, input logic pb, input logic f, input logic b);
    @(posedge ref_clk);
    rxCharValid <= 1'b1;
    rxCharData  <= d;
    rxParityBit <= pb;
    rxFrameBad  <= f;
    rxBreak     <= b;
    @(posedge ref_clk);
    rxCharValid <= 1'b0;
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // A hang counts as a mismatch; the full run needs about 400 cycles.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      close_out();
    end
  end

  // ****
  // Sequence
  // ****
  initial begin
    {rst, psel, penable, pwrite, rxCharValid, rxParityBit, rxFrameBad, rxBreak} = 8'h80;
    paddr = 12'h000;
    pwdata = 32'h0;
    rxCharData = 8'h00;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    rd(`OFS_LINE_COND, "line reset", 8'h00);
    rd(`OFS_PEER_SIG, "peer reset", 8'h00);
    rd(`OFS_CONFIG, "config reset", `CFG_RESET);
    rd(`OFS_IRQ_MASK, "mask reset", 8'h00);
    $display("test reset done");
    foreach (rows[i]) begin
      apb(1'b1, `OFS_CONFIG, {24'h0, rows[i].cfg});
      sendChar(rows[i].data, rows[i].pb, rows[i].frm, rows[i].brk);
      perr = rows[i].cfg[1] && ((^rows[i].data ^ rows[i].pb) == rows[i].cfg[2]);
      rd(`OFS_LINE_COND, "line", {perr | rows[i].frm | rows[i].brk, 4'h0, perr, 2'h1});
      rd(`OFS_RX_DATA, "data", rows[i].data);
      rd(`OFS_LINE_COND, "line after", 8'h00);
    end
    $display("test rows done");
    apb(1'b1, `OFS_CONFIG, 32'h7);
    sendChar(8'h55, 1'b0, 1'b0, 1'b0);
    sendChar(8'h54, 1'b0, 1'b0, 1'b0);
    rd(`OFS_LINE_COND, "head good", 8'h81);
    rd(`OFS_RX_DATA, "first", 8'h55);
    rd(`OFS_LINE_COND, "head bad", 8'h05);
    rd(`OFS_RX_DATA, "second", 8'h54);
    $display("test head parity done");
    apb(1'b1, `OFS_CONFIG, 32'h1);
    for (int i = 0; i <= `FIFO_DEPTH; i++) sendChar(8'(i), 1'b0, 1'b0, 1'b0);
    rd(`OFS_LINE_COND, "overrun", 8'h03);
    for (int i = 0; i < `FIFO_DEPTH; i++) rd(`OFS_RX_DATA, "queued", 8'(i));
    rd(`OFS_LINE_COND, "drained", 8'h00);
    $display("test overrun done");
    for (int i = 0; i < 4; i++) begin
      u_modem_peer.setPins(4'hf & ~(4'h1 << i));
      repeat (8) @(posedge ref_clk);
      rd(`OFS_PEER_SIG, "pin low", (8'h10 << i) | (i == 2 ? 8'h0 : 8'h1 << i));
      rd(`OFS_PEER_SIG, "cleared", 8'h10 << i);
      u_modem_peer.setPins(4'hf);
      repeat (8) @(posedge ref_clk);
      rd(`OFS_PEER_SIG, "pin high", 8'h01 << i);
      rd(`OFS_PEER_SIG, "idle", 8'h00);
    end
    $display("test modem done");
    apb(1'b1, `OFS_CONFIG, 32'h19);
    rd(`OFS_PEER_SIG, "loop on", 8'h11);
    apb(1'b1, `OFS_CONFIG, 32'h1);
    rd(`OFS_PEER_SIG, "loop off", 8'h01);
    $display("test loopback done");
    apb(1'b1, `OFS_IRQ_STAT, 32'h7);
    apb(1'b1, `OFS_IRQ_MASK, 32'h1);
    sendChar(8'h3c, 1'b0, 1'b0, 1'b0);
    repeat (2) @(posedge ref_clk);
    check("irq set", {31'h0, irq}, 32'h1);
    apb(1'b1, `OFS_IRQ_MASK, 32'h0);
    @(posedge ref_clk);
    check("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b1, `OFS_IRQ_MASK, 32'h1);
    rd(`OFS_IRQ_STAT, "irq status", 8'h01);
    check("irq unmasked", {31'h0, irq}, 32'h1);
    apb(1'b1, `OFS_IRQ_STAT, 32'h1);
    repeat (2) @(posedge ref_clk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    rd(`OFS_RX_DATA, "irq char", 8'h3c);
    $display("test irq done");
    apb(1'b0, 12'h020, 32'h0);
    check("unmapped err", {31'h0, rdErr}, 32'h1);
    check("unmapped data", rdData, 32'h0);
    apb(1'b1, 12'h020, 32'hff);
    rd(`OFS_CONFIG, "config kept", 8'h01);
    $display("test unmapped done");
    sendChar(8'h5a, 1'b0, 1'b0, 1'b0);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    check("irq in reset", {31'h0, irq}, 32'h0);
    rd(`OFS_LINE_COND, "line re-reset", 8'h00);
    rd(`OFS_CONFIG, "config re-reset", `CFG_RESET);
    $display("test mid reset done");
    close_out();
  end
endmodule
